// ===== logic/bls_pkg.sv
/*
 * Shared constants for the binary line sensor readout: the sensor end
 * and the scanner controller end both use them.
 * Assumes a single 40 MHz system clock common to both ends.
 */
// Overview of operation
// [RULE1] 2048 pixels, 32 segments of 64, shifted out
// [RULE2] Pixel above reference gives one, else zero
// [RULE3] Exactly 2048 serial bits per scan line
// [RULE4] First bit is the connector end pixel
// [RULE5] Controller supplies start pulse with sampling clock
// [RULE6] Clock after start shows the first pixel
// [RULE7] Each further clock shifts out the next pixel
// [RULE8] Controller stores each captured bit in buffer
// [RULE9] Controller waits for document before capturing lines
// [RULE10] Controller hands line over, repeats while paper present
// [RULE11] Start pulse high across exactly one clock fall
// [RULE12] Line period is interval between start pulses
// [RULE13] Sampling clock between 2.0 and 5.5 MHz; here 5 MHz, but held low with no limit while the FIFO cannot take a byte
// [RULE14] Controller counts 2048 bits; later clocks carry nothing
`default_nettype none
package bls_pkg;
    localparam int unsigned PIXELS        = 2048;
    localparam int unsigned SEGMENTS      = 32;
    localparam int unsigned SEG_PIXELS    = 64;
    localparam int unsigned LEVEL_W       = 8;
    localparam int unsigned CNT_W         = 12;
    localparam int unsigned BYTE_W        = 8;
    localparam int unsigned NBIT_W        = 3;
    localparam int unsigned FIFO_DEPTH    = 16;
    // Timing
    localparam int unsigned SYS_PERIOD_NS = 25;
    localparam int unsigned PCLK_PERIOD_NS = 200;
    localparam int unsigned PCLK_HIGH_NS  = 50;
    localparam int unsigned LINE_MIN_US   = 372;
    localparam int unsigned PCLK_DIV      = PCLK_PERIOD_NS / SYS_PERIOD_NS;
    localparam int unsigned PCLK_HIGH     = PCLK_HIGH_NS / SYS_PERIOD_NS;
    localparam int unsigned LINE_MIN_CYC  =
        (LINE_MIN_US * 1000 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int unsigned PHASE_W       = 3;
    localparam int unsigned TIMER_W       = 16;
    localparam logic [PHASE_W-1:0] PH_SAMPLE = 3'h6;
    localparam logic [PHASE_W-1:0] PH_LAST   = 3'h7;
    localparam logic [CNT_W-1:0]   CNT_ALL   = 12'h800;
    localparam logic [CNT_W-1:0]   CNT_ZERO  = 12'h000;
    localparam logic [NBIT_W-1:0]  NBIT_LAST = 3'h7;
    typedef enum {CS_IDLE, CS_START, CS_SHIFT, CS_DONE} bls_ctl_state_e;
endpackage
`default_nettype wire

// ===== logic/bls_link_if.sv
/*
 * Link between sensor module and scanner controller.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface bls_link_if;
    logic line_start_pulse;   // Start of line, from controller
    logic pixel_sample_clock; // Sampling clock, from controller
    logic serial_pixel_out;   // Binary pixel stream, from sensor
    modport sensor (input line_start_pulse, input pixel_sample_clock,
                    output serial_pixel_out);
    modport ctrl (output line_start_pulse, output pixel_sample_clock,
                  input serial_pixel_out);
endinterface
`default_nettype wire

// ===== logic/bls_sensor.sv
/*
 * Sensor end: captures comparator results at line start and shifts
 * them out one bit per sampling clock rise.
 * Assumes link pins are synchronous to clk_sys_in.
 */
`timescale 1ns/1ps
`default_nettype none
module bls_sensor (
    input  wire logic       clk_sys_in,   // System clock
    input  wire logic       reset_in,     // Async reset, active high
    bls_link_if.sensor      link,         // Link to controller
    input  wire logic [bls_pkg::PIXELS-1:0][bls_pkg::LEVEL_W-1:0]
                            pixel_level_in, // Pixel levels, 0 = connector end
    input  wire logic [bls_pkg::LEVEL_W-1:0]
                            threshold_in  // Comparison reference
);
    logic [bls_pkg::PIXELS-1:0] above;
    logic [bls_pkg::PIXELS-1:0] shreg_r, shreg_nxt;
    logic [bls_pkg::CNT_W-1:0]  left_r, left_nxt;
    logic                       clk_prev_r, out_r, out_nxt;
    logic                       rise, fall;

    // Segment by segment comparator bank
    for (genvar s = 0; s < bls_pkg::SEGMENTS; s++) begin : g_seg
        for (genvar p = 0; p < bls_pkg::SEG_PIXELS; p++) begin : g_pix
            assign above[s*bls_pkg::SEG_PIXELS+p] = // [RULE1] [RULE2]
                pixel_level_in[s*bls_pkg::SEG_PIXELS+p] > threshold_in;
        end
    end

    assign rise = link.pixel_sample_clock & ~clk_prev_r;
    assign fall = ~link.pixel_sample_clock & clk_prev_r;

    always_comb begin
        shreg_nxt = shreg_r;
        left_nxt  = left_r;
        out_nxt   = out_r;
        if (fall && link.line_start_pulse) begin
            shreg_nxt = above;             // Second buffer loaded [RULE1]
            left_nxt  = bls_pkg::CNT_ALL;  // [RULE3]
        end else if (rise) begin
            if (left_r != bls_pkg::CNT_ZERO) begin
                out_nxt   = shreg_r[0];    // [RULE4] [RULE6] [RULE7]
                shreg_nxt = shreg_r >> 1;
                left_nxt  = left_r - 1'b1;
            end else begin
                out_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            shreg_r    <= '0;
            left_r     <= '0;
            out_r      <= 1'b0;
            clk_prev_r <= 1'b0;
        end else begin
            shreg_r    <= shreg_nxt;
            left_r     <= left_nxt;
            out_r      <= out_nxt;
            clk_prev_r <= link.pixel_sample_clock;
        end
    end

    assign link.serial_pixel_out = out_r;
endmodule
`default_nettype wire

// ===== logic/bls_ctrl.sv
/*
 * Scanner controller end with its line buffer FIFO. Generates start
 * pulse and 5 MHz sampling clock, packs pixels into bytes LSB first.
 * Assumes the sensor shares clk_sys_in.
 */
`timescale 1ns/1ps
`default_nettype none
module bls_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             clk_sys_in,     // System clock
    input  wire logic             reset_in,       // Async reset
    input  wire logic             push_valid_in,  // Write request
    output logic                  push_ready_out, // Not full
    input  wire logic [WIDTH-1:0] push_data_in,   // Write data
    output logic                  pop_valid_out,  // Not empty
    input  wire logic             pop_ready_in,   // Read accept
    output logic      [WIDTH-1:0] pop_data_out    // Head word
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_r, wr_nxt, rd_r, rd_nxt;
    logic [AW:0]      cnt_r, cnt_nxt;
    logic             wr, rd;

    assign push_ready_out = cnt_r != DEPTH[AW:0];
    assign pop_valid_out  = cnt_r != '0;
    assign pop_data_out   = mem_r[rd_r];
    assign wr = push_valid_in & push_ready_out;
    assign rd = pop_valid_out & pop_ready_in;

    always_comb begin
        wr_nxt  = wr ? AW'(wr_r + 1'b1) : wr_r;
        rd_nxt  = rd ? AW'(rd_r + 1'b1) : rd_r;
        cnt_nxt = cnt_r;
        if (wr && !rd) cnt_nxt = cnt_r + 1'b1;
        if (rd && !wr) cnt_nxt = cnt_r - 1'b1;
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            wr_r  <= wr_nxt;
            rd_r  <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (wr) mem_r[wr_r] <= push_data_in;
    end
endmodule

module bls_ctrl #(
    parameter int unsigned LINE_CYCLES = bls_pkg::LINE_MIN_CYC
) (
    input  wire logic       clk_sys_in,      // System clock
    input  wire logic       reset_in,        // Async reset, active high
    bls_link_if.ctrl        link,            // Link to sensor
    input  wire logic       scan_enable_in,  // Circuits ready to scan
    input  wire logic       paper_present_in, // Paper sensing switch
    output logic [bls_pkg::BYTE_W-1:0]
                            host_data_out,   // Pixel byte, LSB first pixel
    output logic            host_valid_out,  // Byte available
    input  wire logic       host_ready_in,   // Host takes byte
    output logic            line_done_out,   // One-cycle end of line
    output logic            busy_out         // Line capture running
);
    bls_pkg::bls_ctl_state_e    st_r, st_nxt;
    logic [bls_pkg::PHASE_W-1:0] ph_r, ph_nxt;
    logic [bls_pkg::CNT_W-1:0]   bits_r, bits_nxt;
    logic [bls_pkg::BYTE_W-1:0]  byte_r, byte_nxt, pdata_r, pdata_nxt;
    logic [bls_pkg::NBIT_W-1:0]  nbit_r, nbit_nxt;
    logic [bls_pkg::TIMER_W-1:0] tmr_r, tmr_nxt;
    logic psc_r, psc_nxt, lsp_r, lsp_nxt, push_r, push_nxt;
    logic done_r, done_nxt, busy_r, busy_nxt, fifo_ready;
    logic hold;

    bls_fifo #(
        .WIDTH (bls_pkg::BYTE_W),
        .DEPTH (bls_pkg::FIFO_DEPTH)
    ) u_bls_fifo (
        .clk_sys_in     (clk_sys_in),
        .reset_in       (reset_in),
        .push_valid_in  (push_r),
        .push_ready_out (fifo_ready),
        .push_data_in   (pdata_r),
        .pop_valid_out  (host_valid_out),
        .pop_ready_in   (host_ready_in),
        .pop_data_out   (host_data_out)
    );

    // Wraps the phase counter after the last phase of a period
    function automatic logic [bls_pkg::PHASE_W-1:0] ph_inc(
        input logic [bls_pkg::PHASE_W-1:0] p);
        return (p == bls_pkg::PH_LAST) ? '0 : p + 1'b1;
    endfunction

    // Stall clock low while the buffer cannot take a byte
    assign hold = (ph_r == bls_pkg::PH_LAST) && push_r && !fifo_ready;

    always_comb begin
        st_nxt    = st_r;
        ph_nxt    = ph_r;
        bits_nxt  = bits_r;
        byte_nxt  = byte_r;
        nbit_nxt  = nbit_r;
        pdata_nxt = pdata_r;
        lsp_nxt   = lsp_r;
        done_nxt  = 1'b0;
        push_nxt  = push_r && !fifo_ready; // [RULE8]
        tmr_nxt   = (tmr_r == {bls_pkg::TIMER_W{1'b1}}) ? tmr_r
                                                       : tmr_r + 1'b1;
        case (st_r)
            bls_pkg::CS_IDLE: begin
                ph_nxt = bls_pkg::PH_LAST;
                if (scan_enable_in && paper_present_in) begin // [RULE9]
                    st_nxt  = bls_pkg::CS_START;
                    ph_nxt  = '0;
                    lsp_nxt = 1'b1;                           // [RULE5]
                    tmr_nxt = '0;                             // [RULE12]
                end
            end
            bls_pkg::CS_START: begin
                ph_nxt = ph_inc(ph_r);
                if (ph_r == bls_pkg::PH_LAST) begin
                    lsp_nxt  = 1'b0;  // One fall only [RULE11]
                    st_nxt   = bls_pkg::CS_SHIFT;
                    bits_nxt = bls_pkg::CNT_ZERO;
                    nbit_nxt = '0;
                end
            end
            bls_pkg::CS_SHIFT: begin
                if (!hold) ph_nxt = ph_inc(ph_r);
                if (ph_r == bls_pkg::PH_SAMPLE) begin
                    byte_nxt = {link.serial_pixel_out,
                                byte_r[bls_pkg::BYTE_W-1:1]};
                    nbit_nxt = nbit_r + 1'b1;
                    bits_nxt = bits_r + 1'b1;                 // [RULE14]
                    if (nbit_r == bls_pkg::NBIT_LAST) begin
                        push_nxt  = 1'b1;
                        pdata_nxt = byte_nxt;
                    end
                end
                if (ph_r == bls_pkg::PH_LAST && !hold
                    && bits_r == bls_pkg::CNT_ALL) begin      // [RULE3]
                    st_nxt   = bls_pkg::CS_DONE;
                    done_nxt = 1'b1;                          // [RULE10]
                end
            end
            bls_pkg::CS_DONE: begin
                ph_nxt = bls_pkg::PH_LAST;
                if (tmr_r >= LINE_CYCLES[bls_pkg::TIMER_W-1:0]) begin
                    if (scan_enable_in && paper_present_in) begin
                        st_nxt  = bls_pkg::CS_START;          // [RULE10]
                        ph_nxt  = '0;
                        lsp_nxt = 1'b1;
                        tmr_nxt = '0;                         // [RULE12]
                    end else begin
                        st_nxt = bls_pkg::CS_IDLE;
                    end
                end
            end
            default: st_nxt = bls_pkg::CS_IDLE;
        endcase
        // 200 ns period, 50 ns high [RULE13]
        psc_nxt  = (st_nxt == bls_pkg::CS_START
                    || st_nxt == bls_pkg::CS_SHIFT)
                   && (ph_nxt < bls_pkg::PCLK_HIGH[bls_pkg::PHASE_W-1:0]);
        busy_nxt = st_nxt != bls_pkg::CS_IDLE;
    end

    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            st_r    <= bls_pkg::CS_IDLE;
            ph_r    <= bls_pkg::PH_LAST;
            bits_r  <= '0;
            byte_r  <= '0;
            nbit_r  <= '0;
            pdata_r <= '0;
            tmr_r   <= '0;
            psc_r   <= 1'b0;
            lsp_r   <= 1'b0;
            push_r  <= 1'b0;
            done_r  <= 1'b0;
            busy_r  <= 1'b0;
        end else begin
            st_r    <= st_nxt;
            ph_r    <= ph_nxt;
            bits_r  <= bits_nxt;
            byte_r  <= byte_nxt;
            nbit_r  <= nbit_nxt;
            pdata_r <= pdata_nxt;
            tmr_r   <= tmr_nxt;
            psc_r   <= psc_nxt;
            lsp_r   <= lsp_nxt;
            push_r  <= push_nxt;
            done_r  <= done_nxt;
            busy_r  <= busy_nxt;
        end
    end

    assign link.pixel_sample_clock = psc_r;
    assign link.line_start_pulse   = lsp_r;
    assign line_done_out           = done_r;
    assign busy_out                = busy_r;
endmodule
`default_nettype wire

// ===== testbench/bls_asserts.sv
/* Checker on the three link wires between sensor and controller.
   Assumes one system clock and an asynchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module bls_asserts #(
    parameter int unsigned MIN_GAP = 17000 // Least start to start cycles
) (
    input  wire logic clk_sys_in,         // System clock
    input  wire logic reset_in,           // Async reset, active high
    input  wire logic line_start_pulse,   // Start pulse
    input  wire logic pixel_sample_clock, // Sampling clock
    input  wire logic serial_pixel_out    // Pixel stream
);
    logic        clk_q_r;
    logic        started_r;
    logic [11:0] rise_cnt_r;
    logic        lsp_q_r;
    logic [15:0] gap_r;
    // Counts sampling clock rises since the last start pulse
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            clk_q_r    <= 1'b0;
            started_r  <= 1'b0;
            rise_cnt_r <= 12'h000;
            lsp_q_r    <= 1'b0;
            gap_r      <= 16'h0000;
        end else begin
            clk_q_r <= pixel_sample_clock;
            lsp_q_r <= line_start_pulse;
            // Cycles since the last start pulse rose
            if (line_start_pulse && !lsp_q_r) begin
                gap_r <= 16'h0000;
            end else if (gap_r != 16'hffff) begin
                gap_r <= gap_r + 16'h0001;
            end
            if (line_start_pulse) begin
                started_r  <= 1'b1;
                rise_cnt_r <= 12'h000;
            end else if (pixel_sample_clock && !clk_q_r
                         && rise_cnt_r != 12'hfff) begin
                rise_cnt_r <= rise_cnt_r + 12'h001;
            end
        end
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    sequence s_start_hold;
        line_start_pulse [*8] ##1 !line_start_pulse;
    endsequence
    sequence s_clk_high;
        pixel_sample_clock [*2] ##1 !pixel_sample_clock;
    endsequence
    start_width_a: assert property (
        $rose(line_start_pulse) |-> s_start_hold)
        else $error("start pulse not eight cycles");
    start_phase_a: assert property (
        $rose(line_start_pulse) |-> s_clk_high)
        else $error("clock not high two cycles at start");
    start_on_rise_a: assert property (
        $rose(line_start_pulse) |-> $rose(pixel_sample_clock))
        else $error("start not aligned to clock rise");
    clk_high_a: assert property (
        $rose(pixel_sample_clock) |-> s_clk_high)
        else $error("clock high time wrong");
    clk_period_a: assert property (
        $rose(pixel_sample_clock) |=> (!$rose(pixel_sample_clock)) [*7])
        else $error("clock period below eight cycles");
    line_bits_a: assert property (
        $rose(line_start_pulse) && started_r |-> rise_cnt_r >= 12'h800)
        else $error("new start before all pixels");
    line_gap_a: assert property (
        $rose(line_start_pulse) && started_r |-> gap_r >= MIN_GAP - 1)
        else $error("start pulses closer than line period");
    out_timing_a: assert property (
        $changed(serial_pixel_out) |->
            $past(pixel_sample_clock) && !$past(pixel_sample_clock, 2))
        else $error("pixel output moved off a clock rise");
    reset_idle_a: assert property (
        $fell(reset_in) |->
            !line_start_pulse && !pixel_sample_clock && !serial_pixel_out)
        else $error("link not idle after reset");
endmodule
`default_nettype wire

// ===== testbench/test_binary_line_sensor_readout.sv
/* Bench: sensor and controller joined by the link, bytes checked.
   Assumes package, link, design and checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_binary_line_sensor_readout;
    localparam int unsigned LINE_GAP = 17000;
    logic       clk_sys_in;
    logic       reset_in;
    logic       scan_en;
    logic       paper;
    logic       rdy;
    logic [7:0] hdata;
    logic       hvalid;
    logic       ldone;
    logic       busy;
    logic [7:0] thr;
    logic [bls_pkg::PIXELS-1:0][bls_pkg::LEVEL_W-1:0] lvl;
    int         n_fail;
    int         cmp_count;
    int         nbyte;
    bls_link_if link ();
    bls_sensor u_bls_sensor (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
        .link(link), .pixel_level_in(lvl), .threshold_in(thr));
    bls_ctrl #(.LINE_CYCLES(LINE_GAP)) u_bls_ctrl (.clk_sys_in(clk_sys_in),
        .reset_in(reset_in), .link(link), .scan_enable_in(scan_en),
        .paper_present_in(paper), .host_data_out(hdata),
        .host_valid_out(hvalid), .host_ready_in(rdy),
        .line_done_out(ldone), .busy_out(busy));
    bls_asserts #(.MIN_GAP(LINE_GAP)) u_bls_asserts (.clk_sys_in(clk_sys_in),
        .reset_in(reset_in), .line_start_pulse(link.line_start_pulse),
        .pixel_sample_clock(link.pixel_sample_clock),
        .serial_pixel_out(link.serial_pixel_out));
    task automatic wrap_up();
        if (n_fail == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    function automatic logic [7:0] exp_byte(input int n);
        logic [7:0] b;
        for (int k = 0; k < 8; k++)
            b[k] = lvl[8*n+k] > thr;
        return b;
    endfunction
    // Every popped byte against the levels, earliest pixel in bit 0
    always @(posedge clk_sys_in) begin
        if (hvalid === 1'b1 && rdy) begin
            check(hdata, exp_byte(nbyte));
            nbyte <= nbyte + 1;
        end
    end
    task automatic end_line();
        int i;
        i = 0;
        while (ldone !== 1'b1 && i < 30000) begin
            @(posedge clk_sys_in);
            i++;
        end
        check(ldone, 1'b1);
        while (hvalid === 1'b1)
            @(posedge clk_sys_in);
        check(16'(nbyte), 16'h0100);
        nbyte = 0;
    endtask
    task automatic t_reset();
        repeat (5) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        @(posedge clk_sys_in);
        check({link.line_start_pulse, link.pixel_sample_clock,
               link.serial_pixel_out, hvalid, busy}, 5'h00);
    endtask
    task automatic t_first_line();
        scan_en <= 1'b1;
        repeat (200) @(posedge clk_sys_in);
        check({busy, link.line_start_pulse}, 2'h0);
        paper <= 1'b1;
        end_line();
    endtask
    task automatic t_stall_line();
        thr <= 8'h40;
        rdy <= 1'b0;
        repeat (2500) @(posedge clk_sys_in);
        // Full buffer must hold the sampling clock low
        repeat (30) begin
            @(posedge clk_sys_in);
            check({link.pixel_sample_clock, hvalid, busy}, 3'h3);
        end
        rdy <= 1'b1;
        end_line();
    endtask
    task automatic t_last_line();
        int i;
        i = 0;
        while (link.line_start_pulse !== 1'b1 && i < 20000) begin
            @(posedge clk_sys_in);
            i++;
        end
        paper <= 1'b0;
        end_line();
        i = 0;
        while (busy !== 1'b0 && i < 2000) begin
            @(posedge clk_sys_in);
            i++;
        end
        repeat (300) begin
            @(posedge clk_sys_in);
            check({busy, link.line_start_pulse}, 2'h0);
        end
    endtask
    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        repeat (90000) @(posedge clk_sys_in);
        n_fail++;
        wrap_up();
    end
    initial begin
        reset_in = 1'b1;
        scan_en = 1'b0;
        paper = 1'b0;
        rdy = 1'b1;
        thr = 8'h80;
        n_fail = 0;
        cmp_count = 0;
        nbyte = 0;
        for (int i = 0; i < int'(bls_pkg::PIXELS); i++)
            lvl[i] = 8'(i) + 8'(i >> 8) * 8'h31;
        t_reset();
        t_first_line();
        t_stall_line();
        t_last_line();
        wrap_up();
    end
endmodule
`default_nettype wire
